// >>> hw/ttpl_top.sv
// thermal throttle unit, clock modulation and performance state limit
//
// Operation
// - the throttle unit turns on whenever die temperature reaches the maximum.
// - the activation threshold is 100 degrees Celsius.
// - the threshold is a fixed constant, neither writable nor readable.
// - the clock-stop method gates the core clock at a 50 percent duty cycle while on-demand modulation is off; otherwise the duty value applies.
// - the state-drop method moves to the lowest performance state when hot.
// - the state-drop method exists per variant; without it only clock-stop.
// - automatic and on-demand activation exist; automatic needs no handler.
// - the active-low shutdown output asserts at about 125 degrees Celsius.
// - the shutdown output is independent of activity and makes no bus cycle.
// - the software-selected performance state is applied at runtime.
// - with performance states, a configured frequency ceiling is never exceeded by the chosen state.
// - a variant without performance states runs one fixed frequency.
// - on-demand modulation gates the clock with the configured duty value.
// - the duty value is the percentage of time the clock runs.
`timescale 1ns/1ps
`include "ttpl_consts.svh"
module ttpl_top
  import ttpl_pkg::*;
#(
  parameter bit HAS_PSTATES = 1'b1,
  parameter int NUM_PSTATES = 6
)
(
  // clock and reset
  input wire logic CLK_IN,
  input wire logic RST_IN,
  // on-die sensor, whole degrees Celsius
  input wire logic [7:0] DIE_TEMP_IN,
  // register port
  input wire logic [3:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  output logic [7:0] REG_RDATA_OUT,
  // core clock tree and power control
  output logic CORE_CLK_RUN_OUT,
  output logic [2:0] PERF_STATE_OUT,
  output logic THROTTLE_ACTIVE_OUT,
  output logic OVERTEMP_SHUTDOWN_N_OUT
);

  if (NUM_PSTATES < 1 || NUM_PSTATES > 8)
  begin : g_bad_pstates
    $error("NUM_PSTATES must be 1 to 8");
  end

  localparam logic [2:0] PS_LOW = 3'(NUM_PSTATES - 1);

  ttpl_state_t cur_ff;
  ttpl_state_t nxt_cur;
  ttpl_bus_t bus;

  assign bus = '{addr: REG_ADDR_IN, wdata: REG_WDATA_IN,
                 wr: REG_WR_IN, rd: REG_RD_IN};

  // state 0 is fastest; a larger index is a lower frequency
  function automatic logic [2:0] clamp_ps(input logic [7:0] v);
    clamp_ps = (v > 8'(PS_LOW)) ? PS_LOW : v[2:0];
  endfunction

  logic hot;
  logic trip_now;
  logic throttle_on;
  logic [2:0] sw_ps;
  logic [7:0] on_cyc;

  assign hot = DIE_TEMP_IN >= `TTPL_TEMP_MAX_C;
  assign trip_now = DIE_TEMP_IN >= `TTPL_TEMP_TRIP_C;
  // automatic mode follows the sensor alone; force is the on-demand path
  assign throttle_on = hot || cur_ff.force_auto;
  // the ceiling wins over a faster software choice
  assign sw_ps = (cur_ff.psel < cur_ff.plim) ? cur_ff.plim
                                              : cur_ff.psel;
  // duty given in percent of a 100-cycle period, so it maps one to one
  assign on_cyc = cur_ff.ondem_en ? cur_ff.duty
                                  : (`TTPL_PERIOD_CYC >> 1);

  always_comb
  begin
    nxt_cur = cur_ff;
    nxt_cur.rdata = 8'h00;
    if (bus.wr)
    begin
      unique case (bus.addr)
        `TTPL_ADDR_CTRL:
        begin
          nxt_cur.ondem_en = bus.wdata[`TTPL_CTRL_ONDEM_BIT];
          nxt_cur.force_auto = bus.wdata[`TTPL_CTRL_FORCE_BIT];
        end
        `TTPL_ADDR_DUTY:
          nxt_cur.duty = (bus.wdata > `TTPL_PERIOD_CYC) ?
                         `TTPL_PERIOD_CYC : bus.wdata;
        `TTPL_ADDR_PSEL: nxt_cur.psel = clamp_ps(bus.wdata);
        `TTPL_ADDR_PLIM: nxt_cur.plim = clamp_ps(bus.wdata);
        default: ;
      endcase
    end
    if (bus.rd)
    begin
      // the threshold has no address: it stays invisible to software
      unique case (bus.addr)
        `TTPL_ADDR_CTRL: nxt_cur.rdata = {6'h00, cur_ff.force_auto,
                                          cur_ff.ondem_en};
        `TTPL_ADDR_DUTY: nxt_cur.rdata = cur_ff.duty;
        `TTPL_ADDR_PSEL: nxt_cur.rdata = {5'h00, cur_ff.psel};
        `TTPL_ADDR_PLIM: nxt_cur.rdata = {5'h00, cur_ff.plim};
        `TTPL_ADDR_STAT: nxt_cur.rdata = {cur_ff.trip, cur_ff.gate,
                                          cur_ff.pstate, cur_ff.mode};
        default: nxt_cur.rdata = 8'h00;
      endcase
    end

    unique case (cur_ff.mode)
      TTPL_IDLE:
        if (throttle_on)
          nxt_cur.mode = HAS_PSTATES ? TTPL_PSDROP : TTPL_CLKSTOP;
      TTPL_CLKSTOP, TTPL_PSDROP:
        if (!throttle_on)
          nxt_cur.mode = TTPL_IDLE;
      default: nxt_cur.mode = TTPL_IDLE;
    endcase

    // fixed modulation period shared by both gating sources
    nxt_cur.phase = (cur_ff.phase == `TTPL_PERIOD_CYC - 8'h01) ?
                    8'h00 : cur_ff.phase + 8'h01;
    if (cur_ff.mode == TTPL_CLKSTOP || cur_ff.ondem_en)
      nxt_cur.gate = cur_ff.phase >= on_cyc;
    else
      nxt_cur.gate = 1'b0;

    if (!HAS_PSTATES)
      nxt_cur.pstate = 3'h0;
    else if (cur_ff.mode == TTPL_PSDROP)
      nxt_cur.pstate = PS_LOW;
    else
      nxt_cur.pstate = sw_ps;

    // sticky: cooling alone never withdraws the shutdown request
    if (DIE_TEMP_IN >= `TTPL_TEMP_TRIP_C)
      nxt_cur.trip = 1'b1;
  end

  always_ff @(posedge CLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      cur_ff <= '{mode: TTPL_IDLE, ondem_en: 1'b0, force_auto: 1'b0,
                  duty: `TTPL_DUTY_RST, psel: `TTPL_PSEL_RST,
                  plim: 3'h0, phase: 8'h00, gate: 1'b0,
                  pstate: 3'h0, trip: 1'b0, rdata: 8'h00};
    end
    else
    begin
      cur_ff <= nxt_cur;
    end
  end

  assign REG_RDATA_OUT = cur_ff.rdata;
  assign CORE_CLK_RUN_OUT = !cur_ff.gate;
  assign PERF_STATE_OUT = cur_ff.pstate;
  assign THROTTLE_ACTIVE_OUT = cur_ff.mode != TTPL_IDLE;
  assign OVERTEMP_SHUTDOWN_N_OUT = !cur_ff.trip;

  // building blocks: one sensor condition, one output step later
  sequence hot_seen_s;
    DIE_TEMP_IN >= `TTPL_TEMP_MAX_C;
  endsequence

  sequence throttle_up_s;
    ##1 THROTTLE_ACTIVE_OUT;
  endsequence

  sequence throttle_down_s;
    ##1 !THROTTLE_ACTIVE_OUT;
  endsequence

  sequence cool_s;
    DIE_TEMP_IN < `TTPL_TEMP_MAX_C && !cur_ff.force_auto;
  endsequence

  sequence trip_seen_s;
    DIE_TEMP_IN >= `TTPL_TEMP_TRIP_C;
  endsequence

  sequence shut_low_s;
    ##1 !OVERTEMP_SHUTDOWN_N_OUT;
  endsequence

  sequence clk_runs_s;
    ##1 CORE_CLK_RUN_OUT;
  endsequence

  sequence clk_stops_s;
    ##1 !CORE_CLK_RUN_OUT;
  endsequence

  sequence rdata_clear_s;
    ##1 REG_RDATA_OUT == 8'h00;
  endsequence

  sequence lowest_s;
    ##1 PERF_STATE_OUT == PS_LOW;
  endsequence

  // throttle unit activation
  throttle_on_hot_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    hot_seen_s |-> throttle_up_s)
    else $error("throttle not active while hot");

  threshold_low_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    (DIE_TEMP_IN == 8'h63 && !cur_ff.force_auto) |-> throttle_down_s)
    else $error("throttle active below threshold");

  threshold_exact_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    DIE_TEMP_IN == `TTPL_TEMP_MAX_C |-> throttle_up_s)
    else $error("throttle not active at threshold");

  force_throttle_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    cur_ff.force_auto |-> throttle_up_s)
    else $error("forced throttle not active");

  throttle_release_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    cool_s |-> throttle_down_s)
    else $error("throttle held without cause");

  // method selection per variant
  psdrop_lowest_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    (HAS_PSTATES && cur_ff.mode == TTPL_PSDROP) |-> lowest_s)
    else $error("state drop did not reach lowest state");

  clkstop_method_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    !HAS_PSTATES |-> cur_ff.mode != TTPL_PSDROP)
    else $error("state drop used in a variant without it");

  psdrop_variant_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    (HAS_PSTATES && hot) |=> cur_ff.mode == TTPL_PSDROP)
    else $error("state drop variant used another method");

  clkstop_variant_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    (!HAS_PSTATES && hot) |=> cur_ff.mode == TTPL_CLKSTOP)
    else $error("fixed variant did not stop the clock");

  // catastrophic shutdown
  trip_assert_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    trip_seen_s |-> shut_low_s)
    else $error("shutdown not asserted at trip temperature");

  trip_quiet_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    (!trip_now && OVERTEMP_SHUTDOWN_N_OUT) |=> OVERTEMP_SHUTDOWN_N_OUT)
    else $error("shutdown asserted below trip temperature");

  trip_latched_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    !OVERTEMP_SHUTDOWN_N_OUT |=> !OVERTEMP_SHUTDOWN_N_OUT [*8])
    else $error("shutdown released before reset");

  trip_no_bus_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    ($fell(OVERTEMP_SHUTDOWN_N_OUT) && !$past(REG_RD_IN)) |->
    REG_RDATA_OUT == 8'h00)
    else $error("shutdown produced bus activity");

  // performance state selection
  ceiling_kept_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    (HAS_PSTATES && cur_ff.mode == TTPL_IDLE && $stable(cur_ff.plim))
    |=> PERF_STATE_OUT >= $past(cur_ff.plim))
    else $error("performance state above ceiling");

  psel_applied_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    (HAS_PSTATES && cur_ff.mode == TTPL_IDLE && cur_ff.psel >= cur_ff.plim)
    |=> PERF_STATE_OUT == $past(cur_ff.psel))
    else $error("selected performance state not applied");

  fixed_freq_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    !HAS_PSTATES |-> PERF_STATE_OUT == 3'h0)
    else $error("fixed-frequency variant changed state");

  plim_range_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    cur_ff.plim <= PS_LOW)
    else $error("ceiling outside supported states");

  // clock modulation
  duty_gate_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    (cur_ff.ondem_en && cur_ff.phase < cur_ff.duty) |-> clk_runs_s)
    else $error("clock gated inside on-demand on time");

  duty_off_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    (cur_ff.ondem_en && cur_ff.phase >= cur_ff.duty) |-> clk_stops_s)
    else $error("clock running inside on-demand off time");

  half_duty_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    (cur_ff.mode == TTPL_CLKSTOP && !cur_ff.ondem_en &&
     cur_ff.phase >= 8'h32) |-> clk_stops_s)
    else $error("clock-stop not off in second half");

  half_run_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    (cur_ff.mode == TTPL_CLKSTOP && !cur_ff.ondem_en &&
     cur_ff.phase < 8'h32) |-> clk_runs_s)
    else $error("clock-stop not running in first half");

  no_gate_idle_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    (cur_ff.mode != TTPL_CLKSTOP && !cur_ff.ondem_en) |-> clk_runs_s)
    else $error("clock gated with no modulation source");

  phase_wrap_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    cur_ff.phase == `TTPL_PERIOD_CYC - 8'h01 |=> cur_ff.phase == 8'h00)
    else $error("modulation period did not wrap");

  phase_range_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    cur_ff.phase < `TTPL_PERIOD_CYC)
    else $error("modulation phase out of range");

  duty_range_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    cur_ff.duty <= `TTPL_PERIOD_CYC)
    else $error("duty above one hundred percent");

  // register port
  threshold_hidden_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    (REG_RD_IN && REG_ADDR_IN > `TTPL_ADDR_STAT) |-> rdata_clear_s)
    else $error("unmapped address returned data");

  rdata_idle_a: assert property (
    @(posedge CLK_IN) disable iff (RST_IN)
    !REG_RD_IN |-> rdata_clear_s)
    else $error("read data shown without a read");

endmodule

// >>> hw/ttpl_consts.svh
// constants for the thermal throttle and performance limit block
`ifndef TTPL_CONSTS_SVH
`define TTPL_CONSTS_SVH
`define TTPL_TEMP_MAX_C 8'h64
`define TTPL_TEMP_TRIP_C 8'h7D
`define TTPL_ADDR_CTRL 4'h0
`define TTPL_ADDR_DUTY 4'h1
`define TTPL_ADDR_PSEL 4'h2
`define TTPL_ADDR_PLIM 4'h3
`define TTPL_ADDR_STAT 4'h4
`define TTPL_CTRL_ONDEM_BIT 0
`define TTPL_CTRL_FORCE_BIT 1
`define TTPL_DUTY_RST 8'h64
`define TTPL_PSEL_RST 3'h0
`define TTPL_PERIOD_CYC 8'h64
`endif

// >>> hw/ttpl_pkg.sv
// types shared by the thermal throttle and performance limit block
package ttpl_pkg;
  typedef enum logic [2:0] {
    TTPL_IDLE = 3'b001,
    TTPL_CLKSTOP = 3'b010,
    TTPL_PSDROP = 3'b100
  } ttpl_mode_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ttpl_bus_t;

  typedef struct packed {
    ttpl_mode_t mode;
    logic ondem_en;
    logic force_auto;
    logic [7:0] duty;
    logic [2:0] psel;
    logic [2:0] plim;
    logic [7:0] phase;
    logic gate;
    logic [2:0] pstate;
    logic trip;
    logic [7:0] rdata;
  } ttpl_state_t;
endpackage

// >>> bench/ttpl_power_model.sv
// power supply and clock tree model watching the throttle outputs
`timescale 1ns/1ps
module ttpl_power_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // from the block, plus the count window from the bench
  input wire logic clk_run_in,
  input wire logic shutdown_n_in,
  input wire logic win_in,
  // observations
  output logic [7:0] run_cnt_out,
  output logic power_off_out
);
  logic [7:0] run_cnt_ff;
  logic off_ff;
  assign run_cnt_out = run_cnt_ff;
  assign power_off_out = off_ff;
  // supply stays off once tripped; only a fresh reset brings it back
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      run_cnt_ff <= 8'h00;
      off_ff <= 1'b0;
    end
    else
    begin
      run_cnt_ff <= win_in ? run_cnt_ff + {7'h00, clk_run_in} : 8'h00;
      off_ff <= off_ff | ~shutdown_n_in;
    end
  end
endmodule

// >>> bench/thermal_throttle_and_perf_limit_tb_top.sv
// self-checking bench for the thermal throttle and performance limit block
`timescale 1ns/1ps
`include "ttpl_consts.svh"
module thermal_throttle_and_perf_limit_tb_top;
  logic clk, rst, wr, rd, win, clk_run, thr, sd_n, off;
  logic [3:0] addr;
  logic [7:0] wdata, temp, rdata, run_cnt;
  logic [2:0] pstate;
  logic fx_run, fx_thr;
  logic [2:0] fx_ps;
  int failures, compares, cycles;
  ttpl_top uut (.CLK_IN(clk), .RST_IN(rst), .DIE_TEMP_IN(temp),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr),
    .REG_RD_IN(rd), .REG_RDATA_OUT(rdata), .CORE_CLK_RUN_OUT(clk_run),
    .PERF_STATE_OUT(pstate), .THROTTLE_ACTIVE_OUT(thr),
    .OVERTEMP_SHUTDOWN_N_OUT(sd_n));
  ttpl_power_model pm (.clk_in(clk), .rst_in(rst), .clk_run_in(clk_run),
    .shutdown_n_in(sd_n), .win_in(win), .run_cnt_out(run_cnt),
    .power_off_out(off));
  // second variant without performance states, sharing all inputs
  ttpl_top #(.HAS_PSTATES(1'b0)) uut_fixed (.CLK_IN(clk), .RST_IN(rst),
    .DIE_TEMP_IN(temp), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
    .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_RDATA_OUT(),
    .CORE_CLK_RUN_OUT(fx_run), .PERF_STATE_OUT(fx_ps),
    .THROTTLE_ACTIVE_OUT(fx_thr), .OVERTEMP_SHUTDOWN_N_OUT());
  task automatic conclude;
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] exp, got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] e, string n);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(n, e, rdata);
  endtask
  task automatic t_regs;
    chk("reset outputs", 8'h50, {1'b0, clk_run, thr, sd_n, 1'b0, pstate});
    rd_reg(`TTPL_ADDR_DUTY, `TTPL_DUTY_RST, "duty");
    rd_reg(`TTPL_ADDR_STAT, 8'h01, "stat");
    @(posedge clk);
    #1 chk("rdata drop", 8'h00, rdata);
    wr_reg(`TTPL_ADDR_DUTY, 8'hC8);
    rd_reg(`TTPL_ADDR_DUTY, 8'h64, "duty clamp");
    wr_reg(4'h9, 8'hFF);
    // threshold must not show anywhere in the unmapped space
    for (int a = 5; a < 16; a++)
      rd_reg(a[3:0], 8'h00, "unmapped");
  endtask
  task automatic t_ondemand;
    logic [7:0] duties [2] = '{8'h19, 8'h4B};
    foreach (duties[i])
    begin
      wr_reg(`TTPL_ADDR_DUTY, duties[i]);
      wr_reg(`TTPL_ADDR_CTRL, 8'h01);
      repeat (3) @(posedge clk);
      win <= 1'b1;
      repeat (100) @(posedge clk);
      win <= 1'b0;
      #1 chk("run cycles", duties[i], run_cnt);
    end
    wr_reg(`TTPL_ADDR_CTRL, 8'h00);
  endtask
  task automatic t_pstate;
    wr_reg(`TTPL_ADDR_PSEL, 8'h02);
    repeat (3) @(posedge clk);
    #1 chk("pstate sel", 8'h02, {5'h00, pstate});
    wr_reg(`TTPL_ADDR_PLIM, 8'h04);
    repeat (3) @(posedge clk);
    #1 chk("pstate ceiling", 8'h04, {5'h00, pstate});
    wr_reg(`TTPL_ADDR_PLIM, 8'h07);
    rd_reg(`TTPL_ADDR_PLIM, 8'h05, "plim clamp");
    wr_reg(`TTPL_ADDR_PLIM, 8'h00);
    wr_reg(`TTPL_ADDR_PSEL, 8'h00);
  endtask
  task automatic t_thermal;
    int n = 0;
    wr_reg(`TTPL_ADDR_CTRL, 8'h02);
    rd_reg(`TTPL_ADDR_CTRL, 8'h02, "ctrl force");
    #1 chk("forced", 8'h01, {7'h00, thr});
    wr_reg(`TTPL_ADDR_CTRL, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk("force off", 8'h00, {7'h00, thr});
    @(posedge clk) temp <= 8'h63;
    repeat (3) @(posedge clk);
    #1 chk("below max", 8'h00, {7'h00, thr});
    @(posedge clk) temp <= 8'h64;
    @(posedge clk);
    @(posedge clk);
    #1 chk("throttle on", 8'h01, {7'h00, thr});
    @(posedge clk);
    #1 chk("lowest state", 8'h05, {5'h00, pstate});
    chk("no trip yet", 8'h01, {7'h00, sd_n});
    chk("fixed variant", 8'h08, {4'h0, fx_thr, fx_ps});
    repeat (100)
    begin
      @(posedge clk);
      #1 n += fx_run;
    end
    chk("clock-stop run", 8'h32, 8'(n));
    rd_reg(`TTPL_ADDR_STAT, 8'h2C, "stat hot");
  endtask
  task automatic t_trip;
    @(posedge clk) temp <= 8'h7D;
    @(posedge clk);
    @(posedge clk);
    #1 chk("trip", 8'h00, {7'h00, sd_n});
    @(posedge clk) temp <= 8'h1E;
    repeat (5) @(posedge clk);
    #1 chk("trip held", 8'h02, {6'h00, off, sd_n});
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      failures++;
      conclude();
    end
  end
  initial
  begin
    {rst, wr, rd, win} = 4'h8;
    addr = 4'h0;
    wdata = 8'h00;
    temp = 8'h28;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 t_regs();
    t_ondemand();
    t_pstate();
    t_thermal();
    t_trip();
    conclude();
  end
endmodule
